// *** core/sclkg_core.sv ***
// sclkg_core: AHB-Lite register slave and sample clock selection logic.
// assumes hclk is the only clock; clock sources arrive as plain pins and
// are synchronised, so they must run well below hclk/2 to be followed.
`timescale 1ns/10ps
module sclkg_core
  import sclkg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pll_clk_in,
  input wire logic quartz_div_clk_in,
  input wire logic ext_clk_in,
  output logic sample_clk,
  output logic clk_conn_out,
  output logic clk_conn_oe,
  output logic [31:0] pll_target_hz,
  output logic [31:0] pll_ref_hz,
  output logic pll_ref_external,
  output logic [10:0] quartz_divider
);
  sclkg_cfg_t cfg_r, cfg_nxt;
  logic [2:0] act_src_r, act_src_nxt;
  logic act_ext_r, act_ext_nxt, act_extdiv_r, act_extdiv_nxt;
  logic [7:0] act_div_r, act_div_nxt;
  logic [10:0] act_qdiv_r, act_qdiv_nxt;
  logic [31:0] ach_r, ach_nxt;
  logic [31:0] act_ref_r, act_ref_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [17:0] wa_r, wa_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0] s_pll_r, s_qz_r, s_ext_r;
  logic [7:0] ecnt_r, ecnt_nxt;
  logic ediv_r, ediv_nxt, ext_d_r, ext_d_nxt;
  logic sclk_r, sclk_nxt, cout_r, cout_nxt, coe_r, coe_nxt;
  logic take;
  logic [31:0] lo, hi, clamped, best, bdist, d, qrate;
  logic [10:0] bdiv;
  sclkg_src_t src;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_r;

  // limits of the internal rate
  always_comb begin
    lo = (cfg_r.ctrl.channels == 4'h1) ? MIN1_HZ : MIN_HZ;
    hi = MAX_HZ;
    if (cfg_r.ctrl.fifo_mode && cfg_r.ctrl.channels == 4'hF) begin
      hi = FIFO4_MAX_HZ;
    end
    clamped = cfg_r.rate;
    if (clamped < lo) begin
      clamped = lo;
    end
    if (clamped > hi) begin
      clamped = hi;
    end
  end

  // nearest divided quartz rate; divide is a constant per lane
  always_comb begin
    best = QUARTZ_HZ;
    bdiv = DIVS[0];
    bdist = 32'hFFFF_FFFF;
    qrate = 32'h0000_0000;
    d = 32'h0000_0000;
    for (int i = 0; i < NDIV; i++) begin
      qrate = QUARTZ_HZ / 32'(DIVS[i]);
      d = (qrate > clamped) ? qrate - clamped : clamped - qrate;
      if (qrate <= hi && qrate >= lo && d < bdist) begin
        bdist = d;
        best = qrate;
        bdiv = DIVS[i];
      end
    end
  end

  always_comb begin
    if (!cfg_r.pll_on) begin
      src = SCLKG_QUARTZ;
    end else if (cfg_r.ref_hz != 32'h0000_0000) begin
      src = SCLKG_EXT_PLL;
    end else begin
      src = SCLKG_INT_PLL;
    end
  end

  always_comb begin
    cfg_nxt = cfg_r;
    wr_pend_nxt = take && hwrite;
    wa_nxt = haddr[17:0];
    rd_nxt = rd_r;
    if (wr_pend_r) begin
      case (wa_r)
        ADDR_RATE: cfg_nxt.rate = hwdata;
        ADDR_PLL: cfg_nxt.pll_on = hwdata[0];
        ADDR_CLKOUT: cfg_nxt.drive_out = hwdata[0];
        ADDR_REFFREQ: begin
          // out of range references are ignored; the previous ref_hz is kept
          if (hwdata == 32'h0000_0000 ||
              (hwdata >= REF_MIN_HZ && hwdata <= REF_MAX_HZ)) begin
            cfg_nxt.ref_hz = hwdata;
          end
        end
        ADDR_CTRL: begin
          cfg_nxt.ctrl.run = hwdata[CTRL_RUN];
          cfg_nxt.ctrl.fifo_mode = hwdata[CTRL_FIFO];
          cfg_nxt.ctrl.ext_clock = hwdata[CTRL_EXTCLK];
          cfg_nxt.ctrl.ext_divide = hwdata[CTRL_EXTDIV];
          cfg_nxt.ctrl.channels = hwdata[CTRL_CH_LSB +: 4];
          cfg_nxt.ctrl.ext_div = hwdata[CTRL_DIV_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
    if (take && !hwrite) begin
      case (haddr[17:0])
        ADDR_RATE: rd_nxt = ach_r;
        ADDR_PLL: rd_nxt = {31'h0, cfg_r.pll_on};
        ADDR_CLKOUT: rd_nxt = {31'h0, cfg_r.drive_out};
        ADDR_REFFREQ: rd_nxt = cfg_r.ref_hz;
        ADDR_CTRL: rd_nxt = {16'h0, cfg_r.ctrl.ext_div,
          cfg_r.ctrl.channels, cfg_r.ctrl.ext_divide,
          cfg_r.ctrl.ext_clock, cfg_r.ctrl.fifo_mode, cfg_r.ctrl.run};
        ADDR_STATUS: rd_nxt = {24'h0, act_qdiv_r[7:0] == 8'h0,
          act_extdiv_r, act_ext_r, coe_r, 1'b0, act_src_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // active settings follow the registers only while stopped; ach_r follows them always
  always_comb begin
    act_src_nxt = act_src_r;
    act_ext_nxt = act_ext_r;
    act_extdiv_nxt = act_extdiv_r;
    act_div_nxt = act_div_r;
    act_qdiv_nxt = act_qdiv_r;
    act_ref_nxt = act_ref_r;
    if (!cfg_r.ctrl.run) begin
      act_src_nxt = src;
      act_ext_nxt = cfg_r.ctrl.ext_clock;
      act_extdiv_nxt = cfg_r.ctrl.ext_divide;
      act_div_nxt = cfg_r.ctrl.ext_div;
      act_qdiv_nxt = bdiv;
      act_ref_nxt = (src == SCLKG_EXT_PLL) ? cfg_r.ref_hz : INT_REF_HZ;
    end
    ach_nxt = (src == SCLKG_QUARTZ) ? best : clamped;
  end

  // divided external clock: toggle every ext_div+1 rising edges
  always_comb begin
    ext_d_nxt = s_ext_r[1];
    ecnt_nxt = ecnt_r;
    ediv_nxt = ediv_r;
    if (s_ext_r[1] && !ext_d_r) begin
      if (ecnt_r >= act_div_r) begin
        ecnt_nxt = 8'h00;
        ediv_nxt = !ediv_r;
      end else begin
        ecnt_nxt = ecnt_r + 8'h01;
      end
    end
  end

  always_comb begin
    if (act_ext_r) begin
      sclk_nxt = act_extdiv_r ? ediv_r : s_ext_r[1];
    end else if (act_src_r == SCLKG_QUARTZ) begin
      sclk_nxt = s_qz_r[1];
    end else begin
      sclk_nxt = s_pll_r[1];
    end
    // judged on the next active source so oe never lags a source change
    coe_nxt = cfg_r.drive_out && !act_ext_nxt &&
              act_src_nxt != SCLKG_EXT_PLL;
    cout_nxt = coe_nxt && sclk_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= '{rate: RATE_RST, pll_on: PLL_RST, drive_out: 1'b0,
                 ref_hz: 32'h0, ctrl: '0};
      act_src_r <= SCLKG_INT_PLL;
      act_ext_r <= 1'b0;
      act_extdiv_r <= 1'b0;
      act_div_r <= 8'h00;
      act_qdiv_r <= 11'h001;
      // a cleared request reads back as the floor
      ach_r <= MIN_HZ;
      act_ref_r <= INT_REF_HZ;
      wr_pend_r <= 1'b0;
      wa_r <= 18'h00000;
      rd_r <= 32'h0000_0000;
      s_pll_r <= 2'b00;
      s_qz_r <= 2'b00;
      s_ext_r <= 2'b00;
      ecnt_r <= 8'h00;
      ediv_r <= 1'b0;
      ext_d_r <= 1'b0;
      sclk_r <= 1'b0;
      cout_r <= 1'b0;
      coe_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      act_src_r <= act_src_nxt;
      act_ext_r <= act_ext_nxt;
      act_extdiv_r <= act_extdiv_nxt;
      act_div_r <= act_div_nxt;
      act_qdiv_r <= act_qdiv_nxt;
      ach_r <= ach_nxt;
      act_ref_r <= act_ref_nxt;
      wr_pend_r <= wr_pend_nxt;
      wa_r <= wa_nxt;
      rd_r <= rd_nxt;
      s_pll_r <= {s_pll_r[0], pll_clk_in};
      s_qz_r <= {s_qz_r[0], quartz_div_clk_in};
      s_ext_r <= {s_ext_r[0], ext_clk_in};
      ecnt_r <= ecnt_nxt;
      ediv_r <= ediv_nxt;
      ext_d_r <= ext_d_nxt;
      sclk_r <= sclk_nxt;
      cout_r <= cout_nxt;
      coe_r <= coe_nxt;
    end
  end

  assign sample_clk = sclk_r;
  assign clk_conn_out = cout_r;
  assign clk_conn_oe = coe_r;
  assign pll_target_hz = ach_r;
  assign pll_ref_hz = act_ref_r;
  assign pll_ref_external = act_src_r == SCLKG_EXT_PLL;
  assign quartz_divider = act_qdiv_r;

  a_rate_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (act_src_r != SCLKG_QUARTZ) |-> ach_r >= MIN_HZ)
    else $error("achieved rate below floor");
  a_one_ch_floor: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg_r.ctrl.channels == 4'h1 && cfg_r.pll_on) |=> ach_r >= MIN1_HZ)
    else $error("single channel rate below 2 MHz");
  a_rate_ceiling: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> ach_r <= MAX_HZ)
    else $error("rate above maximum");
  a_fifo4_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg_r.ctrl.fifo_mode && cfg_r.ctrl.channels == 4'hF) |=>
    ach_r <= FIFO4_MAX_HZ)
    else $error("four channel fifo rate above cap");
  a_out_internal: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_conn_oe |-> (!act_ext_r && act_src_r != SCLKG_EXT_PLL))
    else $error("clock driven out on external source");
  a_out_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_conn_oe |-> clk_conn_out == sample_clk)
    else $error("driven clock differs from sample clock");
  a_hold_running: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r.ctrl.run && $past(cfg_r.ctrl.run) |-> $stable(act_src_r) &&
    $stable(act_qdiv_r) && $stable(act_div_r))
    else $error("clock setup changed while running");
  a_bypass_src: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cfg_r.pll_on && !cfg_r.ctrl.run) [*2] |=>
    act_src_r == SCLKG_QUARTZ)
    else $error("bypass not selected");
  a_bypass_read: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg_r.pll_on |=> ach_r * 32'(act_qdiv_r) <= QUARTZ_HZ ||
    cfg_r.ctrl.run)
    else $error("bypass rate not a quartz division");
  a_ref_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r.ctrl.run && $past(cfg_r.ctrl.run) |-> $stable(pll_ref_hz))
    else $error("pll reference changed while running");
  a_ref_range: assert property (@(posedge hclk) disable iff (!hresetn)
    pll_ref_external |-> pll_ref_hz >= REF_MIN_HZ &&
    pll_ref_hz <= REF_MAX_HZ)
    else $error("external reference outside range");
  c_bypass: cover property (@(posedge hclk) act_src_r == SCLKG_QUARTZ);
  c_ext_ref: cover property (@(posedge hclk) act_src_r == SCLKG_EXT_PLL);
  c_drive: cover property (@(posedge hclk) clk_conn_oe && sample_clk);
  c_ext_div: cover property (@(posedge hclk) act_extdiv_r && ediv_r);
  c_ext_direct: cover property (@(posedge hclk)
    act_ext_r && !act_extdiv_r && sclk_r);
endmodule

// *** shared/sclkg_pkg.sv ***
// sclkg_pkg: register map, field layout and constants of the sample clock
// generator; shared by the core and by the verification side.
package sclkg_pkg;
  // printed offsets are not all multiples of four: they are indexes
  localparam logic [15:0] IDX_RATE = 16'h4E20;
  localparam logic [15:0] IDX_PLL = 16'h4E3E;
  localparam logic [15:0] IDX_CLKOUT = 16'h4E8E;
  localparam logic [15:0] IDX_REFFREQ = 16'h4EAC;
  localparam logic [15:0] IDX_CTRL = 16'h4F00;
  localparam logic [15:0] IDX_STATUS = 16'h4F01;
  localparam logic [17:0] ADDR_RATE = {IDX_RATE, 2'b00};
  localparam logic [17:0] ADDR_PLL = {IDX_PLL, 2'b00};
  localparam logic [17:0] ADDR_CLKOUT = {IDX_CLKOUT, 2'b00};
  localparam logic [17:0] ADDR_REFFREQ = {IDX_REFFREQ, 2'b00};
  localparam logic [17:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [17:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  // ctrl fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_FIFO = 1;
  localparam int CTRL_EXTCLK = 2;
  localparam int CTRL_EXTDIV = 3;
  localparam int CTRL_CH_LSB = 4;
  localparam int CTRL_DIV_LSB = 8;
  // rates in Hz
  localparam logic [31:0] INT_REF_HZ = 32'h0262_5A00;   // 40 MHz
  localparam logic [31:0] QUARTZ_HZ = 32'h0773_5940;    // 125 MHz
  localparam logic [31:0] MAX_HZ = 32'h0773_5940;       // 125 MS/s
  localparam logic [31:0] FIFO4_MAX_HZ = 32'h03B9_ACA0; // 62.5 MS/s
  localparam logic [31:0] MIN_HZ = 32'h0000_03E8;       // 1 kHz
  localparam logic [31:0] MIN1_HZ = 32'h001E_8480;      // 2 MHz
  localparam logic [31:0] REF_MIN_HZ = 32'h000F_4240;   // 1 MHz
  localparam logic [31:0] REF_MAX_HZ = 32'h0773_5940;   // 125 MHz
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam logic PLL_RST = 1'b1;
  localparam int NDIV = 17;
  localparam logic [10:0] DIVS [NDIV] = '{
    11'h001, 11'h002, 11'h004, 11'h008, 11'h00A, 11'h010, 11'h014,
    11'h028, 11'h032, 11'h050, 11'h064, 11'h0C8, 11'h190, 11'h1F4,
    11'h320, 11'h3E8, 11'h7D0};
  typedef enum logic [2:0] {
    SCLKG_INT_PLL = 3'b001,
    SCLKG_QUARTZ = 3'b010,
    SCLKG_EXT_PLL = 3'b100
  } sclkg_src_t;
  typedef struct packed {
    logic run;
    logic fifo_mode;
    logic ext_clock;
    logic ext_divide;
    logic [3:0] channels;
    logic [7:0] ext_div;
  } sclkg_ctrl_t;
  typedef struct packed {
    logic [31:0] rate;
    logic pll_on;
    logic drive_out;
    logic [31:0] ref_hz;
    sclkg_ctrl_t ctrl;
  } sclkg_cfg_t;
endpackage

// *** testbench/tb.sv ***
// tb: self-checking bench for sclkg_core, driven over AHB-Lite.
// assumes a zero-wait slave; the clock pins come from slow bench counters.
`timescale 1ns/10ps
module tb;
  import sclkg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, pll_target_hz, pll_ref_hz, rd, ex;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pll_clk_in, quartz_div_clk_in, ext_clk_in, prev;
  logic sample_clk, clk_conn_out, clk_conn_oe, pll_ref_external;
  logic [10:0] quartz_divider;
  logic [7:0] ph;
  int mismatches, check_count, n, m;
  assign hready = hreadyout;
  sclkg_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pll_clk_in(pll_clk_in),
    .quartz_div_clk_in(quartz_div_clk_in), .ext_clk_in(ext_clk_in),
    .sample_clk(sample_clk), .clk_conn_out(clk_conn_out),
    .clk_conn_oe(clk_conn_oe), .pll_target_hz(pll_target_hz),
    .pll_ref_hz(pll_ref_hz), .pll_ref_external(pll_ref_external),
    .quartz_divider(quartz_divider));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // pins stay well under hclk/4 so the synchronisers can follow them
  always @(posedge hclk) begin
    ph <= hresetn ? ph + 8'h01 : 8'h00;
    pll_clk_in <= ph[2];
    quartz_div_clk_in <= ph[3];
    ext_clk_in <= ph[4];
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  // entered right after a rising edge; returns on the data phase edge
  task automatic xfer(logic [15:0] idx, logic w, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask
  // derived rate settles a cycle after the write, so give it room
  task automatic wr(logic [15:0] idx, logic [31:0] d);
    xfer(idx, 1'b1, d);
    repeat (3) @(posedge hclk);
  endtask
  task automatic rdc(string nm, logic [15:0] idx, logic [31:0] m,
                     logic [31:0] e);
    xfer(idx, 1'b0, 32'h0000_0000);
    chk(nm, e, rd & m);
  endtask
  task automatic rate(logic [31:0] c, logic [31:0] q, logic [31:0] e);
    wr(IDX_CTRL, c);
    wr(IDX_RATE, q);
    rdc("rate readback", IDX_RATE, 32'hFFFF_FFFF, e);
    chk("target", e, pll_target_hz);
  endtask
  task automatic rises(int cyc);
    logic po;
    n = 0;
    m = 0;
    prev = sample_clk;
    po = clk_conn_out;
    repeat (cyc) begin
      @(posedge hclk);
      if (prev === 1'b0 && sample_clk === 1'b1)
        n++;
      if (po === 1'b0 && clk_conn_out === 1'b1)
        m++;
      prev = sample_clk;
      po = clk_conn_out;
    end
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    mismatches = 0;
    check_count = 0;
    // the whole run needs a few thousand cycles; this only catches a hang
    fork
      begin
        repeat (40000) @(posedge hclk);
        $display("BAD run expected finished seen timeout");
        mismatches++;
        final_report();
      end
    join_none
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("pll mode", IDX_PLL, 32'hFFFF_FFFF, 32'h0000_0001);
    rdc("source", IDX_STATUS, 32'h0000_0007, 32'h0000_0001);
    chk("ref hz", INT_REF_HZ, pll_ref_hz);
    rdc("unmapped", 16'h0040, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test reset done");
    rate(32'h0000_0030, 32'h000F_4240, 32'h000F_4240);
    rate(32'h0000_0030, 32'h0000_01F4, MIN_HZ);
    rate(32'h0000_0010, 32'h000F_4240, MIN1_HZ);
    rate(32'h0000_0030, 32'h0BEB_C200, MAX_HZ);
    rate(32'h0000_00F0, 32'h0BEB_C200, MAX_HZ);
    rate(32'h0000_00F2, 32'h0BEB_C200, FIFO4_MAX_HZ);
    rate(32'h0000_0032, 32'h0BEB_C200, MAX_HZ);
    rate(32'h0000_00F2, INT_REF_HZ, INT_REF_HZ);
    $display("test rate limits done");
    wr(IDX_CTRL, 32'h0000_0030);
    wr(IDX_PLL, 32'h0000_0000);
    rdc("source", IDX_STATUS, 32'h0000_0007, 32'h0000_0002);
    for (int i = 0; i < NDIV; i++) begin
      ex = QUARTZ_HZ / {21'h000000, DIVS[i]};
      wr(IDX_RATE, ex);
      rdc("bypass rate", IDX_RATE, 32'hFFFF_FFFF, ex);
      chk("divider", {21'h000000, DIVS[i]}, {21'h000000, quartz_divider});
    end
    rate(32'h0000_0030, 32'h01C9_C380, 32'h01DC_D650);
    chk("divider", 32'h0000_0004, {21'h000000, quartz_divider});
    rate(32'h0000_0030, 32'h0BEB_C200, QUARTZ_HZ);
    $display("test quartz done");
    wr(IDX_CTRL, 32'h0000_0031);
    wr(IDX_RATE, 32'h00BE_BC20);
    chk("held divider", 32'h0000_0001, {21'h000000, quartz_divider});
    rises(320);
    chk("quartz edges", 32'h0000_0001, {31'h0, n >= 19 && n <= 21});
    wr(IDX_CTRL, 32'h0000_0030);
    chk("new divider", 32'h0000_000A, {21'h000000, quartz_divider});
    wr(IDX_PLL, 32'h0000_0001);
    rdc("source", IDX_STATUS, 32'h0000_0007, 32'h0000_0001);
    $display("test run lock done");
    wr(IDX_REFFREQ, 32'h0098_9680);
    chk("ref external", 32'h0000_0001, {31'h0, pll_ref_external});
    chk("ref hz", 32'h0098_9680, pll_ref_hz);
    rdc("source", IDX_STATUS, 32'h0000_0007, 32'h0000_0004);
    wr(IDX_REFFREQ, 32'h0007_A120);
    chk("ref low refused", 32'h0098_9680, pll_ref_hz);
    wr(IDX_REFFREQ, 32'h0BEB_C200);
    chk("ref high refused", 32'h0098_9680, pll_ref_hz);
    wr(IDX_REFFREQ, REF_MAX_HZ);
    chk("ref top", REF_MAX_HZ, pll_ref_hz);
    wr(IDX_REFFREQ, 32'h0000_0000);
    chk("ref external", 32'h0000_0000, {31'h0, pll_ref_external});
    chk("ref hz", INT_REF_HZ, pll_ref_hz);
    $display("test reference done");
    wr(IDX_CLKOUT, 32'h0000_0001);
    chk("drive out", 32'h0000_0001, {31'h0, clk_conn_oe});
    rdc("status oe", IDX_STATUS, 32'h0000_0010, 32'h0000_0010);
    wr(IDX_CTRL, 32'h0000_0031);
    rises(400);
    chk("pll edges", 32'h0000_0001, {31'h0, n >= 48 && n <= 52});
    chk("out edges", 32'h0000_0001, {31'h0, m >= 48 && m <= 52});
    wr(IDX_CTRL, 32'h0000_0030);
    wr(IDX_CTRL, 32'h0000_013C);
    chk("drive out ext", 32'h0000_0000, {31'h0, clk_conn_oe});
    wr(IDX_CTRL, 32'h0000_013D);
    rises(1280);
    chk("ext div edges", 32'h0000_0001, {31'h0, n >= 9 && n <= 11});
    chk("out edges off", 32'h0000_0000, m);
    wr(IDX_CTRL, 32'h0000_0034);
    wr(IDX_CTRL, 32'h0000_0035);
    rises(640);
    chk("ext edges", 32'h0000_0001, {31'h0, n >= 19 && n <= 21});
    $display("test clock out done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("reset oe", 32'h0000_0000, {31'h0, clk_conn_oe});
    chk("reset divider", 32'h0000_0001, {21'h000000, quartz_divider});
    chk("reset ref", INT_REF_HZ, pll_ref_hz);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("pll mode", IDX_PLL, 32'hFFFF_FFFF, 32'h0000_0001);
    rdc("source", IDX_STATUS, 32'h0000_0007, 32'h0000_0001);
    rdc("rate floor", IDX_RATE, 32'hFFFF_FFFF, MIN_HZ);
    $display("test reset again done");
    final_report();
  end
endmodule
